// ### adc_sequencing_control_tb.sv
// self-checking bench for the converter sequencing control
`timescale 1ns/10ps
`default_nettype none
`include "adcsc_map.svh"
module adc_sequencing_control_tb;
   logic        clk = 1'b0, srst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, ce = 1'b1;
   logic [2:0]  addr = 3'h0;
   logic [7:0]  wdata = 8'h00, rdata, ien = 8'h00;
   logic [11:0] core_data, value = 12'hA5C;
   logic        irq, tsens, cpow, tick, samp, conv, res10;
   logic [1:0]  rate;
   logic [2:0]  src;
   int          n_mismatch = 0, samples_checked = 0, cyc = 0;
   int          tick_cnt = 0, last_tick = 0, gap = 1, gap_err = 0;
   // =========================================
   // clock, tick spacing monitor and hang guard
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (tick) begin
         if (tick_cnt != 0 && cyc - last_tick != gap) gap_err++;
         last_tick = cyc;
         tick_cnt++;
      end
      if (cyc > 60000) begin
         n_mismatch++;
         conclude();
      end
   end
   adcsc_ctrl dut_u (.CLK(clk), .SRST(srst), .CE(ce), .ADDR(addr), .WR_DATA(wdata),
      .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rdata), .CORE_DATA(core_data), .IRQ(irq),
      .TSENS_ON(tsens), .CONV_POWER(cpow), .CONV_TICK(tick), .SAMPLING(samp),
      .CONVERTING(conv), .RES_10BIT(res10), .RATE_MODE(rate), .INPUT_SRC(src));
   adcsc_core_model core_u (.CLK(clk), .CONVERTING(conv), .CONV_POWER(cpow),
      .VALUE(value), .CORE_DATA(core_data));
   // =========================================
   // bus and compare tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic wait_idle;
      int k;
      for (k = 0; k < 20000 && (samp || conv); k++) @(posedge clk);
      repeat (3) @(posedge clk);
   endtask
   // one conversion, counted tick by tick; busy, flag and results judged after
   task automatic run_conv(input logic [2:0] code, input logic [2:0] s, input logic [7:0] j,
                           input logic [7:0] n, input logic [7:0] hi, input logic [7:0] lo);
      wr(`ADCSC_A_CTRL_SECOND, {s, 2'b00, code});
      gap = 1 << code;
      tick_cnt = 0;
      gap_err = 0;
      wr(`ADCSC_A_IRQ_CTRL, ien);
      wr(`ADCSC_A_CTRL_FIRST, 8'hA0 | j);
      repeat (4) @(posedge clk);
      wr(`ADCSC_A_CTRL_FIRST, 8'h20 | j);
      rd(`ADCSC_A_CTRL_FIRST, 8'h60 | j);
      chk({5'h00, src}, {5'h00, s});
      chk({7'h0, cpow}, 8'h01);
      wait_idle();
      chk(8'(tick_cnt), n);
      chk(8'(gap_err), 8'h00);
      rd(`ADCSC_A_CTRL_FIRST, 8'h20 | j);
      rd(`ADCSC_A_IRQ_CTRL, 8'h01 | ien);
      chk({7'h0, irq}, {7'h0, ien[1]});
      wr(`ADCSC_A_IRQ_CTRL, 8'h01 | ien);
      repeat (2) @(posedge clk);
      #1 chk({7'h0, irq}, 8'h00);
      rd(`ADCSC_A_RESULT_HIGH, hi);
      rd(`ADCSC_A_RESULT_LOW, lo);
   endtask
   // =========================================
   // scenarios
   task automatic t_reset;
      int i;
      wr(3'h6, 8'hFF);
      wr(`ADCSC_A_CTRL_FIRST, 8'h40);
      for (i = 0; i < 8; i++) rd(3'(i), (i == 2) ? 8'h02 : 8'h00);
      $display("reset values done");
   endtask
   task automatic t_third;
      int i;
      wr(`ADCSC_A_CTRL_THIRD, 8'hFF);
      rd(`ADCSC_A_CTRL_THIRD, 8'hE3);
      chk({4'h0, tsens, res10, rate}, 8'h0F);
      for (i = 0; i < 4; i++) begin
         wr(`ADCSC_A_CTRL_THIRD, {2'(i), 6'h02});
         repeat (2) @(posedge clk);
         #1 chk({4'h0, tsens, res10, rate}, {6'h00, 2'(i)});
      end
      $display("third control done");
   endtask
   task automatic t_divider;
      int i;
      for (i = 0; i < 8; i++) run_conv(3'(i), 3'h0, 8'h00, 8'd16, 8'hA5, 8'hC0);
      $display("divider codes done");
   endtask
   task automatic t_refuse;
      value = 12'h3C1;
      wr(`ADCSC_A_CTRL_FIRST, 8'h80);
      wr(`ADCSC_A_CTRL_FIRST, 8'h00);
      repeat (3) @(posedge clk);
      #1 chk({7'h0, samp}, 8'h00);
      wr(`ADCSC_A_CTRL_FIRST, 8'hA0);
      repeat (4) @(posedge clk);
      #1 chk({7'h0, samp}, 8'h00);
      wr(`ADCSC_A_CTRL_FIRST, 8'h20);
      repeat (2) @(posedge clk);
      #1 chk({7'h0, samp}, 8'h01);
      wr(`ADCSC_A_CTRL_FIRST, 8'h00);
      wait_idle();
      chk({7'h0, cpow}, 8'h00);
      rd(`ADCSC_A_CTRL_FIRST, 8'h00);
      rd(`ADCSC_A_IRQ_CTRL, 8'h00);
      rd(`ADCSC_A_RESULT_HIGH, 8'hA5);
      rd(`ADCSC_A_RESULT_LOW, 8'hC0);
      value = 12'hA5C;
      $display("refusals and abort done");
   endtask
   task automatic t_modes;
      wr(`ADCSC_A_CTRL_THIRD, 8'h03);
      run_conv(3'h6, `ADCSC_SRC_TEMP, 8'h10, 8'd58, 8'h0A, 8'h5C);
      chk({7'h0, tsens}, 8'h01);
      wr(`ADCSC_A_CTRL_THIRD, 8'h22);
      ien = 8'h02;
      run_conv(3'h5, 3'h0, 8'h00, 8'd16, 8'h97, 8'h00);
      run_conv(3'h7, 3'h0, 8'h10, 8'd16, 8'h02, 8'h5C);
      wr(`ADCSC_A_CTRL_FIRST, 8'h00);
      $display("modes and formats done");
   endtask
   // a write while the clock enable is low must leave the register alone
   task automatic t_freeze;
      @(posedge clk);
      ce <= 1'b0;
      wr(`ADCSC_A_CTRL_SECOND, 8'hA5);
      ce <= 1'b1;
      rd(`ADCSC_A_CTRL_SECOND, 8'h07);
      $display("clock enable freeze done");
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // =========================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_third();
      t_divider();
      t_refuse();
      t_modes();
      t_freeze();
      conclude();
   end
endmodule
`default_nettype wire

// ### adcsc_core_model.sv
// behavioural converter core that returns a fixed code during conversions
`timescale 1ns/10ps
`default_nettype none
module adcsc_core_model (
   input  wire logic        CLK,        // system clock
   input  wire logic        CONVERTING, // conversion phase
   input  wire logic        CONV_POWER, // core power
   input  wire logic [11:0] VALUE,      // code to return
   output logic      [11:0] CORE_DATA   // result to the control
);
   logic        conv_d = 1'b0;
   logic [11:0] junk   = 12'h3A7;
   // =========================================
   // output logic
   // code is valid only in the conversion phase plus one cycle; it churns
   // otherwise, so a load taken at the wrong moment shows up
   always_ff @(posedge CLK) begin
      conv_d <= CONVERTING;
      junk   <= ~junk;
   end
   assign CORE_DATA = (CONV_POWER && (CONVERTING || conv_d)) ? VALUE : junk ^ ~VALUE;
endmodule
`default_nettype wire

// ### adcsc_ctrl.sv
// converter sequencing control: registers, clock divider, conversion sequencer
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "adcsc_map.svh"
// Contract
// R01 - resolution bit: zero gives twelve-bit, one gives ten-bit conversion
// R02 - temperature sensor powered only while its enable bit is set
// R03 - software uses the sensor only at twelve-bit and fastest rate mode
// R04 - conversion starts after the start bit goes low-high-low
// R05 - busy flag set once a conversion starts, held until it finishes
// R06 - busy flag cleared on completion, usable as end-of-conversion poll
// R07 - completion sets interrupt flag; interrupt raised only when enabled
// R08 - two-bit rate mode field selects 2MHz, 1MHz, 500kHz or low current
// R09 - converter clock is system clock divided by two to the divider code
// R10 - software keeps converter clock period between 0.5us and 10us
// R11 - sensor conversion at twelve-bit uses rate mode 00
// R12 - power-enable bit switches converter on when set, off when cleared
// R13 - software waits a settling delay after power-on before starting
// R14 - software clears power-enable when conversions are not needed
// R15 - normal conversion takes 4 sampling plus 12 conversion clocks
// R16 - sensor conversion takes 46 sampling plus 12 conversion clocks
// R17 - result registers unchanged while converter is powered off
// R18 - format bit selects left- or right-justified result placement
// R19 - unused bits of the third control register read zero, ignore writes
// R20 - software always writes one to the reserved bit
module adcsc_ctrl
   import adcsc_pkg::*;
(
   input  wire logic        CLK,        // system clock
   input  wire logic        SRST,       // synchronous reset, active high
   input  wire logic        CE,         // clock enable, freezes all state
   input  wire logic [2:0]  ADDR,       // register index
   input  wire logic [7:0]  WR_DATA,    // write data
   input  wire logic        WR_EN,      // write strobe
   input  wire logic        RD_EN,      // read strobe
   output logic      [7:0]  RD_DATA,    // read data, cycle after strobe
   input  wire logic [11:0] CORE_DATA,  // converted value from the core
   output logic             IRQ,        // interrupt to the converter vector
   output logic             TSENS_ON,   // temperature sensor power
   output logic             CONV_POWER, // converter core power
   output logic             CONV_TICK,  // converter clock pulse
   output logic             SAMPLING,   // sampling phase
   output logic             CONVERTING, // conversion phase
   output logic             RES_10BIT,  // ten-bit resolution selected
   output logic      [1:0]  RATE_MODE,  // converter rate mode to the core
   output logic      [2:0]  INPUT_SRC   // input source select to the core
);
   // ==========================================================
   // register state
   logic [7:0]   first;
   logic [7:0]   second;
   logic [7:0]   third;
   logic [7:0]   result_high;
   logic [7:0]   result_low;
   logic         irq_flag;
   logic         irq_en;
   logic [6:0]   div_cnt;
   logic [5:0]   phase_cnt;
   adcsc_state_t state;

   // power-of-two divider mask for a three-bit code
   function automatic logic [6:0] div_mask(input logic [2:0] code);
      div_mask = 7'(({7'h00, 1'b1} << code) - 8'h01);
   endfunction

   // ==========================================================
   // decode and selection
   wire       wr_first  = WR_EN && ADDR == `ADCSC_A_CTRL_FIRST;
   wire       wr_second = WR_EN && ADDR == `ADCSC_A_CTRL_SECOND;
   wire       wr_third  = WR_EN && ADDR == `ADCSC_A_CTRL_THIRD;
   wire       wr_irq    = WR_EN && ADDR == `ADCSC_A_IRQ_CTRL;
   wire       power     = first[`ADCSC_B_POWER];
   wire       res10     = third[`ADCSC_B_RES];
   wire [2:0] div_code  = second[`ADCSC_F_DIV_HI:`ADCSC_F_DIV_LO];
   wire       is_temp   = second[`ADCSC_F_SRC_HI:`ADCSC_F_SRC_LO] == `ADCSC_SRC_TEMP;
   // a pulse is complete when the start bit, already high, is written low
   wire       launch    = wr_first && first[`ADCSC_B_START] && !WR_DATA[`ADCSC_B_START]
                          && power && state == ADCSC_IDLE; // R04
   // converter clock: every 2^code system clocks
   wire       tick      = (div_cnt | ~div_mask(div_code)) == 7'h7F; // R09
   wire [5:0] sample_len = is_temp ? `ADCSC_SAMPLE_TEMP : `ADCSC_SAMPLE_NORM; // R15 R16
   wire [5:0] phase_end = state == ADCSC_SAMPLE ? sample_len : `ADCSC_CONVERT_LEN;
   wire       last_tick = tick && phase_cnt == 6'(phase_end - 6'h01);
   wire       done      = state == ADCSC_CONVERT && last_tick && power;
   // result placement: left or right justified at either resolution
   wire [15:0] left_v   = res10 ? {CORE_DATA[9:0], 6'h00} : {CORE_DATA, 4'h0};
   wire [15:0] right_v  = res10 ? {6'h00, CORE_DATA[9:0]} : {4'h0, CORE_DATA};
   wire [15:0] placed   = first[`ADCSC_B_JUSTIFY] ? right_v : left_v; // R18
   wire [7:0]  third_rd = {third[7:5], 3'h0, third[1:0]}; // R19
   logic [7:0] rd_mux;

   always_comb begin
      unique case (ADDR)
         `ADCSC_A_CTRL_FIRST:  rd_mux = {first[7], state != ADCSC_IDLE, first[5:0]};
         `ADCSC_A_CTRL_SECOND: rd_mux = second;
         `ADCSC_A_CTRL_THIRD:  rd_mux = third_rd;
         `ADCSC_A_RESULT_HIGH: rd_mux = result_high;
         `ADCSC_A_RESULT_LOW:  rd_mux = result_low;
         `ADCSC_A_IRQ_CTRL:    rd_mux = {6'h00, irq_en, irq_flag};
         default:              rd_mux = 8'h00;
      endcase
   end

   // ==========================================================
   // control registers; busy bit is never stored, it is the sequencer state
   always_ff @(posedge CLK) begin
      if (SRST) begin
         first  <= 8'h00;
         second <= 8'h00;
         third  <= `ADCSC_THIRD_RESET;
         irq_en <= 1'b0;
      end else if (CE) begin
         if (wr_first)
            first <= {WR_DATA[7], 1'b0, WR_DATA[5:0]};
         if (wr_second)
            second <= WR_DATA;
         if (wr_third)
            third <= {WR_DATA[7:5], 3'h0, WR_DATA[1:0]}; // R19
         if (wr_irq)
            irq_en <= WR_DATA[`ADCSC_B_IRQ_EN];
      end
   end

   // interrupt flag: completion wins over a write-one-to-clear in the same cycle
   always_ff @(posedge CLK) begin
      if (SRST)
         irq_flag <= 1'b0;
      else if (CE) begin
         if (done)
            irq_flag <= 1'b1; // R07
         else if (wr_irq && WR_DATA[`ADCSC_B_IRQ_FLAG])
            irq_flag <= 1'b0;
      end
   end

   // divider runs freely so the converter clock has no start-up phase shift
   always_ff @(posedge CLK) begin
      if (SRST)
         div_cnt <= 7'h00;
      else if (CE)
         div_cnt <= 7'(div_cnt + 7'h01);
   end

   // ==========================================================
   // sequencer; dropping power aborts without touching results or flag
   always_ff @(posedge CLK) begin
      if (SRST) begin
         state     <= ADCSC_IDLE;
         phase_cnt <= 6'h00;
      end else if (CE) begin
         unique case (state)
            ADCSC_IDLE: begin
               phase_cnt <= 6'h00;
               if (launch)
                  state <= ADCSC_SAMPLE; // R05
            end
            ADCSC_SAMPLE: begin
               if (!power)
                  state <= ADCSC_IDLE; // R12
               else if (last_tick) begin
                  state     <= ADCSC_CONVERT;
                  phase_cnt <= 6'h00;
               end else if (tick)
                  phase_cnt <= 6'(phase_cnt + 6'h01);
            end
            ADCSC_CONVERT: begin
               if (!power || last_tick)
                  state <= ADCSC_IDLE; // R06
               else if (tick)
                  phase_cnt <= 6'(phase_cnt + 6'h01);
            end
         endcase
      end
   end

   // results load only on a powered completion, otherwise hold
   always_ff @(posedge CLK) begin
      if (SRST) begin
         result_high <= 8'h00;
         result_low  <= 8'h00;
      end else if (CE && done) begin
         result_high <= placed[15:8]; // R17
         result_low  <= placed[7:0];
      end
   end

   // ==========================================================
   // registered outputs
   always_ff @(posedge CLK) begin
      if (SRST) begin
         RD_DATA    <= 8'h00;
         IRQ        <= 1'b0;
         TSENS_ON   <= 1'b0;
         CONV_POWER <= 1'b0;
         CONV_TICK  <= 1'b0;
         SAMPLING   <= 1'b0;
         CONVERTING <= 1'b0;
         RES_10BIT  <= 1'b0;
         RATE_MODE  <= 2'h0;
         INPUT_SRC  <= 3'h0;
      end else if (CE) begin
         RD_DATA    <= RD_EN ? rd_mux : 8'h00;
         IRQ        <= irq_flag && irq_en; // R07
         TSENS_ON   <= third[`ADCSC_B_TEMP_EN]; // R02
         CONV_POWER <= power; // R12
         CONV_TICK  <= tick && state != ADCSC_IDLE;
         SAMPLING   <= state == ADCSC_SAMPLE;
         CONVERTING <= state == ADCSC_CONVERT;
         RES_10BIT  <= res10; // R01
         RATE_MODE  <= third[`ADCSC_F_RATE_HI:`ADCSC_F_RATE_LO]; // R08
         INPUT_SRC  <= second[`ADCSC_F_SRC_HI:`ADCSC_F_SRC_LO];
      end
   end

   // ==========================================================
   // checks
   property p_res;
      @(posedge CLK) disable iff (SRST) CE && $changed(res10) |=> RES_10BIT == $past(res10);
   endproperty
   a_res: assert property (p_res) else $error("resolution output wrong"); // R01

   property p_tsens;
      @(posedge CLK) disable iff (SRST) CE && !third[`ADCSC_B_TEMP_EN] |=> !TSENS_ON;
   endproperty
   a_tsens: assert property (p_tsens) else $error("sensor on while disabled"); // R02

   property p_launch;
      @(posedge CLK) disable iff (SRST) CE && launch |=> state == ADCSC_SAMPLE && phase_cnt == 6'h00;
   endproperty
   a_launch: assert property (p_launch) else $error("start pulse did not launch"); // R04 R05

   property p_done;
      @(posedge CLK) disable iff (SRST) CE && done |=> state == ADCSC_IDLE && irq_flag;
   endproperty
   a_done: assert property (p_done) else $error("completion did not clear busy"); // R06 R07

   property p_irq;
      @(posedge CLK) disable iff (SRST) CE && !irq_en ##1 CE |-> !IRQ;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt while disabled"); // R07

   property p_div;
      @(posedge CLK) disable iff (SRST) div_code == 3'h7 && tick |-> div_cnt == 7'h7F;
   endproperty
   a_div: assert property (p_div) else $error("divide by 128 wrong"); // R09

   property p_sample;
      @(posedge CLK) disable iff (SRST)
         CE && state == ADCSC_SAMPLE && power && last_tick && !is_temp |-> phase_cnt == 6'h03;
   endproperty
   a_sample: assert property (p_sample) else $error("sampling length wrong"); // R15

   property p_temp;
      @(posedge CLK) disable iff (SRST)
         CE && state == ADCSC_SAMPLE && power && last_tick && is_temp
         |-> phase_cnt == 6'h2D ##1 state == ADCSC_CONVERT;
   endproperty
   a_temp: assert property (p_temp) else $error("sensor sampling end wrong"); // R16

   property p_hold;
      @(posedge CLK) disable iff (SRST) !power |=> $stable(result_high) && $stable(result_low);
   endproperty
   a_hold: assert property (p_hold) else $error("results moved while off"); // R17

   property p_unused;
      @(posedge CLK) disable iff (SRST)
         CE && RD_EN && ADDR == `ADCSC_A_CTRL_THIRD |=> RD_DATA[4:2] == 3'h0;
   endproperty
   a_unused: assert property (p_unused) else $error("unused bits read nonzero"); // R19
endmodule
`default_nettype wire

// ### adcsc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef ADCSC_MAP_SVH
`define ADCSC_MAP_SVH
// ==========================================================
// register indices
`define ADCSC_A_CTRL_FIRST   3'h0
`define ADCSC_A_CTRL_SECOND  3'h1
`define ADCSC_A_CTRL_THIRD   3'h2
`define ADCSC_A_RESULT_HIGH  3'h3
`define ADCSC_A_RESULT_LOW   3'h4
`define ADCSC_A_IRQ_CTRL     3'h5
// ==========================================================
// converter_control_first fields
`define ADCSC_B_START        7
`define ADCSC_B_BUSY         6
`define ADCSC_B_POWER        5
`define ADCSC_B_JUSTIFY      4
// converter_control_second fields
`define ADCSC_F_SRC_HI       7
`define ADCSC_F_SRC_LO       5
`define ADCSC_F_DIV_HI       2
`define ADCSC_F_DIV_LO       0
`define ADCSC_SRC_TEMP       3'h2
// converter_control_third fields
`define ADCSC_F_RATE_HI      7
`define ADCSC_F_RATE_LO      6
`define ADCSC_B_RES          5
`define ADCSC_B_RSV_ONE      1
`define ADCSC_B_TEMP_EN      0
`define ADCSC_THIRD_RESET    8'h02
// irq control fields
`define ADCSC_B_IRQ_FLAG     0
`define ADCSC_B_IRQ_EN       1
// ==========================================================
// phase lengths in converter clocks
`define ADCSC_SAMPLE_NORM    6'h04
`define ADCSC_SAMPLE_TEMP    6'h2E
`define ADCSC_CONVERT_LEN    6'h0C
`endif

// ### adcsc_pkg.sv
// types shared by the converter sequencing control
package adcsc_pkg;
   typedef enum logic [1:0] {
      ADCSC_IDLE,
      ADCSC_SAMPLE,
      ADCSC_CONVERT
   } adcsc_state_t;
endpackage
